// ==== logic/tca_device.sv ====
// transfer controller: activation, transfer engine and completion handling
// Behaviour
// - enabled source interrupt starts its transfer
// - interrupt completion clears enable, requests cpu
// - cpu gets the original source interrupt
// - intermediate clears source flag; last keeps it
// - normal mode: count decrements, pointers step
// - block mode: block size reloads, block count decrements
// - mode select: 00 normal, 10 block
// - step select 00 fixed, 10 increment; byte size
// - vector address from vector number via table
// - soft start: write top bit plus vector
// - host checks soft bit clear before start
// - host reads back vector, retries on mismatch
// - soft single transfer without interrupt clears bit
// - soft completion keeps bit, raises done irq
// - no done irq while soft transfer pending
// - done handler clears soft bit
// - host re-enables source to continue
// - module stop; stop write refused while busy
// - host clears enables before module stop
// - host keeps ram enable set
// - enable bits changed by read-modify-write
// - chain blocks: no cpu irq, flag untouched
// - repeat mode never completes by count
`default_nettype none
module tca_device (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic [tca_pkg::N_SRC-1:0] src_flag_i,
  output logic [tca_pkg::N_SRC-1:0] src_clr_o,
  tca_if.dev link
);
  import tca_pkg::*;

  typedef enum logic [5:0] {
    S_IDLE = 6'b000001,
    S_VEC = 6'b000010,
    S_INFO = 6'b000100,
    S_MOVE = 6'b001000,
    S_BACK = 6'b010000,
    S_END = 6'b100000
  } tca_state_type;

  function automatic logic [15:0] step_ptr(input logic [15:0] p, input logic [1:0] sel,
                                           input logic sz);
    logic [15:0] d;
    d = sz ? 16'h0002 : 16'h0001;
    if (sel == STEP_INC) step_ptr = p + d;
    else if (sel == STEP_DEC) step_ptr = p - d;
    else step_ptr = p;
  endfunction

  function automatic logic [15:0] rewind_ptr(input logic [15:0] p, input logic [1:0] sel,
                                             input logic sz, input logic [7:0] n);
    logic [15:0] span;
    span = {7'h00, (n == 8'h00), n} << sz;
    if (sel == STEP_INC) rewind_ptr = p - span;
    else if (sel == STEP_DEC) rewind_ptr = p + span;
    else rewind_ptr = p;
  endfunction

  logic [7:0] mem [0:RAM_DEPTH-1];
  tca_state_type state;
  logic [N_SRC-1:0] enable;
  logic soft_activate_bit;
  logic [6:0] soft_vec;
  logic soft_end;
  logic mstop;
  logic ram_en;
  logic [3:0] idx;
  logic [15:0] ri_base;
  logic [RI_W-1:0] ri;
  logic phase;
  logic cnt_done;
  logic by_soft;
  logic [2:0] act_src;
  logic [6:0] act_vec;
  logic [N_SRC-1:0] hw_pend;
  logic soft_pend;
  logic start;
  logic [2:0] pick;
  logic acc;
  logic ram_acc;
  logic [10:0] rd_addr;
  logic [7:0] rd_byte;

  wire logic [7:0] mode_word_a = ri[79:72];
  wire logic [7:0] mode_word_b = ri[71:64];
  wire logic [15:0] source_pointer = ri[63:48];
  wire logic [15:0] dest_pointer = ri[47:32];
  wire logic [15:0] count_word_a = ri[31:16];
  wire logic [15:0] count_word_b = ri[15:0];
  wire logic [1:0] mode = mode_word_a[MRA_MODE+1:MRA_MODE];
  wire logic sz = mode_word_a[MRA_SZ];
  wire logic irq_due = cnt_done | mode_word_b[MRB_PER_TRANSFER_IRQ_SELECT];

  always_comb begin
    hw_pend = src_flag_i & enable & ~src_clr_o;
    soft_pend = soft_activate_bit & ~soft_end;
    start = (state == S_IDLE) && !mstop && ram_en && ((|hw_pend) || soft_pend);
    pick = 3'd0;
    for (int i = N_SRC - 1; i >= 0; i--) begin
      if (hw_pend[i]) pick = i[2:0];
    end
  end

  assign acc = link.req && !link.ack;
  assign ram_acc = link.addr < RAM_LIMIT;

  // address of the byte the engine reads this cycle
  always_comb begin
    unique case (state)
      S_VEC: rd_addr = VEC_TABLE + {3'b000, act_vec, 1'b0} + {10'h000, idx[0]};
      S_INFO: rd_addr = ri_base[10:0] + {7'h00, idx};
      S_MOVE: rd_addr = source_pointer[10:0] + {10'h000, phase};
      default: rd_addr = link.addr[10:0];
    endcase
    rd_byte = mem[rd_addr];
  end

  // transfer engine sequencing
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= S_IDLE;
      idx <= 4'h0;
      phase <= 1'b0;
      ri_base <= 16'h0000;
      ri <= '0;
      cnt_done <= 1'b0;
      by_soft <= 1'b0;
      act_src <= 3'd0;
      act_vec <= 7'h00;
    end else begin
      unique case (state)
        S_IDLE: begin
          idx <= 4'h0;
          if (start) begin
            state <= S_VEC;
            by_soft <= ~(|hw_pend);
            act_src <= pick;
            act_vec <= (|hw_pend) ? SRC_VEC_BASE + {4'h0, pick} : soft_vec;
          end
        end
        S_VEC: begin
          if (idx[0]) begin
            ri_base[7:0] <= rd_byte;
            idx <= 4'h0;
            state <= S_INFO;
          end else begin
            ri_base[15:8] <= rd_byte;
            idx <= 4'h1;
          end
        end
        S_INFO: begin
          ri[RI_W-1-8*idx -: 8] <= rd_byte;
          phase <= 1'b0;
          if (idx == 4'(RI_BYTES - 1)) begin
            idx <= 4'h0;
            state <= S_MOVE;
          end else begin
            idx <= idx + 4'h1;
          end
        end
        S_MOVE: begin
          if (phase != sz) begin
            phase <= 1'b1;
          end else begin
            phase <= 1'b0;
            ri[63:48] <= step_ptr(source_pointer, mode_word_a[MRA_SSEL+1:MRA_SSEL], sz);
            ri[47:32] <= step_ptr(dest_pointer, mode_word_a[MRA_DSEL+1:MRA_DSEL], sz);
            if (mode == MODE_BLOCK) begin
              if (count_word_a[7:0] == 8'h01) begin
                ri[23:16] <= count_word_a[15:8];
                ri[15:0] <= count_word_b - 16'h0001;
                cnt_done <= (count_word_b == 16'h0001);
                if (mode_word_a[MRA_DTS]) begin
                  ri[63:48] <= rewind_ptr(step_ptr(source_pointer, mode_word_a[MRA_SSEL+1:MRA_SSEL], sz),
                                          mode_word_a[MRA_SSEL+1:MRA_SSEL], sz, count_word_a[15:8]);
                end else begin
                  ri[47:32] <= rewind_ptr(step_ptr(dest_pointer, mode_word_a[MRA_DSEL+1:MRA_DSEL], sz),
                                          mode_word_a[MRA_DSEL+1:MRA_DSEL], sz, count_word_a[15:8]);
                end
                state <= S_BACK;
              end else begin
                ri[23:16] <= count_word_a[7:0] - 8'h01;
              end
            end else if (mode == MODE_REPEAT) begin
              cnt_done <= 1'b0;
              ri[23:16] <= (count_word_a[7:0] == 8'h01) ? count_word_a[15:8] : count_word_a[7:0] - 8'h01;
              if (count_word_a[7:0] == 8'h01 && mode_word_a[MRA_DTS]) begin
                ri[63:48] <= rewind_ptr(step_ptr(source_pointer, mode_word_a[MRA_SSEL+1:MRA_SSEL], sz),
                                        mode_word_a[MRA_SSEL+1:MRA_SSEL], sz, count_word_a[15:8]);
              end else if (count_word_a[7:0] == 8'h01) begin
                ri[47:32] <= rewind_ptr(step_ptr(dest_pointer, mode_word_a[MRA_DSEL+1:MRA_DSEL], sz),
                                        mode_word_a[MRA_DSEL+1:MRA_DSEL], sz, count_word_a[15:8]);
              end
              state <= S_BACK;
            end else begin
              ri[31:16] <= count_word_a - 16'h0001;
              cnt_done <= (count_word_a == 16'h0001);
              state <= S_BACK;
            end
          end
        end
        S_BACK: begin
          if (idx == 4'(RI_BYTES - 1)) begin
            idx <= 4'h0;
            if (mode_word_b[MRB_CHAIN_ENABLE]) begin
              ri_base <= ri_base + 16'(RI_BYTES);
              state <= S_INFO;
            end else begin
              state <= S_END;
            end
          end else begin
            idx <= idx + 4'h1;
          end
        end
        S_END: state <= S_IDLE;
      endcase
    end
  end

  // engine and host share one write port; host ram writes only while idle
  always_ff @(posedge core_clk_i) begin
    if (state == S_MOVE) mem[dest_pointer[10:0] + {10'h000, phase}] <= rd_byte;
    else if (state == S_BACK) mem[ri_base[10:0] + {7'h00, idx}] <= ri[RI_W-1-8*idx -: 8];
    else if (state == S_IDLE && !start && acc && ram_acc && link.we) begin
      mem[link.addr[10:0]] <= link.wdata;
    end
  end

  // source flags, enable bits and cpu interrupt lines
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      enable <= ENABLE_RST;
      src_clr_o <= '0;
      link.cpu_irq <= '0;
    end else begin
      src_clr_o <= '0;
      link.cpu_irq <= src_flag_i & ~enable;
      if (state == S_END && !by_soft && !irq_due) src_clr_o[act_src] <= 1'b1;
      if (acc && !ram_acc && link.we && link.addr == REG_ENABLE) enable <= link.wdata;
      else if (state == S_END && !by_soft && irq_due) enable[act_src] <= 1'b0;
    end
  end

  // software activation bit and completion state
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      soft_activate_bit <= 1'b0;
      soft_vec <= 7'h00;
      soft_end <= 1'b0;
    end else begin
      if (acc && !ram_acc && link.we && link.addr == REG_SOFT_VEC) begin
        if (!link.wdata[SOFT_BIT]) begin
          soft_activate_bit <= 1'b0;
          soft_end <= 1'b0;
        end else if (!soft_activate_bit) begin
          soft_activate_bit <= 1'b1;
          soft_vec <= link.wdata[6:0];
          soft_end <= 1'b0;
        end
      end
      if (state == S_END && by_soft) begin
        if (irq_due) soft_end <= 1'b1;
        else soft_activate_bit <= 1'b0;
      end
    end
  end

  // control bits and register port answers
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      mstop <= 1'b0;
      ram_en <= SYSCTL_RST;
      link.ack <= 1'b0;
      link.rdata <= 8'h00;
      link.soft_done_irq <= 1'b0;
      link.busy <= 1'b0;
    end else begin
      link.ack <= 1'b0;
      link.busy <= (state != S_IDLE) || start;
      link.soft_done_irq <= soft_activate_bit && soft_end && state == S_IDLE;
      if (acc && !ram_acc) begin
        link.ack <= 1'b1;
        // refuse on the live engine state, the registered busy lags a start by one cycle
        if (link.we && link.addr == REG_MSTOP &&
            (!link.wdata[0] || (state == S_IDLE && !start))) begin
          mstop <= link.wdata[0];
        end
        if (link.we && link.addr == REG_SYSCTL) ram_en <= link.wdata[0];
        unique case (link.addr)
          REG_ENABLE: link.rdata <= enable;
          REG_SOFT_VEC: link.rdata <= {soft_activate_bit, soft_vec};
          REG_MSTOP: link.rdata <= {7'h00, mstop};
          REG_SYSCTL: link.rdata <= {7'h00, ram_en};
          REG_STATUS: link.rdata <= {6'h00, soft_end, link.busy};
          default: link.rdata <= 8'h00;
        endcase
      end else if (acc && state == S_IDLE && !start) begin
        link.ack <= 1'b1;
        link.rdata <= rd_byte;
      end
    end
  end
endmodule
`default_nettype wire

// ==== logic/tca_pkg.sv ====
// constants shared by both ends of the transfer controller activation link
`default_nettype none
package tca_pkg;
  localparam int N_SRC = 8;
  localparam int ADDR_W = 12;
  localparam int RAM_DEPTH = 2048;
  localparam int RAM_AW = 11;
  localparam int RI_BYTES = 10;
  localparam int RI_W = 80;
  // device register addresses on the link
  localparam logic [11:0] REG_ENABLE = 12'h0800;
  localparam logic [11:0] REG_SOFT_VEC = 12'h0801;
  localparam logic [11:0] REG_MSTOP = 12'h0802;
  localparam logic [11:0] REG_SYSCTL = 12'h0803;
  localparam logic [11:0] REG_STATUS = 12'h0804;
  localparam logic [11:0] RAM_LIMIT = 12'h0800;
  // host command words on avalon (word addresses)
  localparam logic [11:0] CMD_SOFT = 12'h0800;
  localparam logic [11:0] CMD_EN_SET = 12'h0801;
  localparam logic [11:0] CMD_EN_CLR = 12'h0802;
  localparam logic [11:0] CMD_SOFT_CLR = 12'h0803;
  localparam logic [11:0] CMD_STOP = 12'h0804;
  localparam logic [11:0] CMD_STATUS = 12'h0805;
  localparam logic [11:0] CMD_SYSCTL = 12'h0806;
  // vector table and reset values
  localparam logic [10:0] VEC_TABLE = 11'h0400;
  localparam logic [6:0] SRC_VEC_BASE = 7'h40;
  localparam logic [7:0] ENABLE_RST = 8'h00;
  localparam logic SYSCTL_RST = 1'b1;
  // mode_word_a fields
  localparam int MRA_SSEL = 6;
  localparam int MRA_DSEL = 4;
  localparam int MRA_MODE = 2;
  localparam int MRA_DTS = 1;
  localparam int MRA_SZ = 0;
  // mode_word_b fields
  localparam int MRB_CHAIN_ENABLE = 7;
  localparam int MRB_PER_TRANSFER_IRQ_SELECT = 6;
  localparam int SOFT_BIT = 7;
  localparam logic [1:0] MODE_NORMAL = 2'b00;
  localparam logic [1:0] MODE_REPEAT = 2'b01;
  localparam logic [1:0] MODE_BLOCK = 2'b10;
  localparam logic [1:0] STEP_INC = 2'b10;
  localparam logic [1:0] STEP_DEC = 2'b11;
endpackage
`default_nettype wire

// ==== logic/tca_if.sv ====
// link between the transfer controller and its cpu side controller
`default_nettype none
interface tca_if;
  import tca_pkg::*;
  logic req;
  logic we;
  logic [ADDR_W-1:0] addr;
  logic [7:0] wdata;
  logic ack;
  logic [7:0] rdata;
  logic [N_SRC-1:0] cpu_irq;
  logic soft_done_irq;
  logic busy;
  modport dev (input req, we, addr, wdata, output ack, rdata, cpu_irq, soft_done_irq, busy);
  modport host (output req, we, addr, wdata, input ack, rdata, cpu_irq, soft_done_irq, busy);
endinterface
`default_nettype wire

// ==== logic/tca_host.sv ====
// cpu side controller: avalon slave that runs command sequences on the link
`default_nettype none
module tca_host (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic [11:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output logic [tca_pkg::N_SRC-1:0] cpu_irq_o,
  output logic soft_done_irq_o,
  tca_if.host link
);
  import tca_pkg::*;

  typedef enum logic [2:0] {
    H_IDLE = 3'b001,
    H_ISSUE = 3'b010,
    H_FIN = 3'b100
  } tca_hstate_type;

  tca_hstate_type state;
  logic [11:0] cmd;
  logic [7:0] arg;
  logic [1:0] step;
  logic soft_ok;
  logic stop_ok;

  assign avs_waitrequest_o = (avs_read_i || avs_write_i) && state != H_FIN;
  assign cpu_irq_o = link.cpu_irq;
  assign soft_done_irq_o = link.soft_done_irq;

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= H_IDLE;
      cmd <= 12'h000;
      arg <= 8'h00;
      step <= 2'd0;
      soft_ok <= 1'b0;
      stop_ok <= 1'b0;
      avs_readdata_o <= 32'h0000_0000;
      link.req <= 1'b0;
      link.we <= 1'b0;
      link.addr <= 12'h000;
      link.wdata <= 8'h00;
    end else begin
      unique case (state)
        H_IDLE: begin
          cmd <= avs_address_i;
          arg <= avs_writedata_i[7:0];
          step <= 2'd0;
          link.req <= 1'b0;
          if (avs_address_i < RAM_LIMIT && (avs_read_i || avs_write_i)) begin
            link.req <= 1'b1;
            link.we <= avs_write_i;
            link.addr <= avs_address_i;
            link.wdata <= avs_writedata_i[7:0];
            state <= H_ISSUE;
          end else if (avs_read_i) begin
            avs_readdata_o <= {22'h00_0000, stop_ok, soft_ok, link.cpu_irq};
            if (avs_address_i == CMD_STATUS) begin
              avs_readdata_o <= {22'h00_0000, soft_done_irq_o, link.busy, link.cpu_irq};
            end
            state <= H_FIN;
          end else if (avs_write_i) begin
            link.req <= 1'b1;
            link.we <= 1'b0;
            link.addr <= REG_SOFT_VEC;
            link.wdata <= 8'h00;
            unique case (avs_address_i)
              CMD_SOFT: link.addr <= REG_SOFT_VEC;
              CMD_EN_SET, CMD_EN_CLR: link.addr <= REG_ENABLE;
              CMD_SOFT_CLR: link.we <= 1'b1;
              CMD_STOP: begin
                link.we <= 1'b1;
                link.addr <= avs_writedata_i[0] ? REG_ENABLE : REG_MSTOP;
                step <= avs_writedata_i[0] ? 2'd0 : 2'd1;
              end
              CMD_SYSCTL: begin
                link.we <= 1'b1;
                link.addr <= REG_SYSCTL;
                link.wdata <= 8'h01;
              end
              default: link.req <= 1'b0;
            endcase
            state <= (avs_address_i >= CMD_SOFT && avs_address_i <= CMD_SYSCTL &&
                      avs_address_i != CMD_STATUS) ? H_ISSUE : H_FIN;
          end
        end
        H_ISSUE: begin
          if (link.ack) begin
            link.req <= 1'b0;
            avs_readdata_o <= {24'h00_0000, link.rdata};
            state <= H_FIN;
            if (cmd == CMD_SOFT) begin
              if (step == 2'd0 && !link.rdata[SOFT_BIT]) begin
                link.req <= 1'b1;
                link.we <= 1'b1;
                link.wdata <= {1'b1, arg[6:0]};
                step <= 2'd1;
              end else if (step == 2'd1) begin
                link.req <= 1'b1;
                link.we <= 1'b0;
                step <= 2'd2;
              end else begin
                soft_ok <= step == 2'd2 && link.rdata == {1'b1, arg[6:0]};
                link.req <= !(step == 2'd2 && link.rdata == {1'b1, arg[6:0]});
                link.we <= 1'b0;
                step <= 2'd0;
              end
              if (!(step == 2'd2 && link.rdata == {1'b1, arg[6:0]})) state <= H_ISSUE;
            end else if ((cmd == CMD_EN_SET || cmd == CMD_EN_CLR) && step == 2'd0) begin
              link.req <= 1'b1;
              link.we <= 1'b1;
              link.wdata <= (cmd == CMD_EN_SET) ? link.rdata | (8'h01 << arg[2:0])
                                                : link.rdata & ~(8'h01 << arg[2:0]);
              step <= 2'd1;
              state <= H_ISSUE;
            end else if (cmd == CMD_STOP && step != 2'd2) begin
              link.req <= 1'b1;
              link.we <= step == 2'd0;
              link.addr <= REG_MSTOP;
              link.wdata <= {7'h00, arg[0]};
              step <= step + 2'd1;
              state <= H_ISSUE;
            end else if (cmd == CMD_STOP) begin
              stop_ok <= link.rdata[0] == arg[0];
            end
          end
        end
        H_FIN: state <= H_IDLE;
        default: state <= H_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// ==== tb/tca_asserts.sv ====
// concurrent checks on the link between the controller and its cpu side
`default_nettype none
module tca_asserts (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic req,
  input wire logic we,
  input wire logic [tca_pkg::ADDR_W-1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic ack,
  input wire logic [7:0] rdata,
  input wire logic [tca_pkg::N_SRC-1:0] cpu_irq,
  input wire logic soft_done_irq,
  input wire logic busy
);
  import tca_pkg::*;
  logic idle_seen;
  logic wr_done;
  logic en_rd_ok;
  logic en_zero;
  logic stopped;
  logic [7:0] en_rd;
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      idle_seen <= 1'b0;
      wr_done <= 1'b0;
      en_rd_ok <= 1'b0;
      en_rd <= 8'h00;
      en_zero <= 1'b1;
      stopped <= 1'b0;
    end else if (req && ack) begin
      wr_done <= we && addr == REG_SOFT_VEC && wdata[SOFT_BIT];
      en_rd_ok <= !we && addr == REG_ENABLE;
      en_rd <= rdata;
      if (addr == REG_SOFT_VEC) begin
        idle_seen <= !we && !rdata[SOFT_BIT];
      end
      if (we && addr == REG_ENABLE) begin
        en_zero <= wdata == 8'h00;
      end
      if (!we && addr == REG_MSTOP) begin
        stopped <= rdata[0];
      end else if (we && addr == REG_MSTOP && !wdata[0]) begin
        stopped <= 1'b0;
      end
    end
  end
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  sequence s_soft_start;
    req && we && addr == REG_SOFT_VEC && wdata[SOFT_BIT];
  endsequence
  sequence s_soft_clear;
    ack && we && addr == REG_SOFT_VEC && !wdata[SOFT_BIT];
  endsequence
  a_ack_one_cycle: assert property (ack |=> !ack)
    else $error("ack held longer than one cycle");
  a_req_held: assert property (req && !ack |=> req && $stable(addr) && $stable(we))
    else $error("request changed before ack");
  a_soft_idle_check: assert property (s_soft_start |-> idle_seen)
    else $error("soft start without idle check");
  a_soft_readback: assert property (req && wr_done |-> !we && addr == REG_SOFT_VEC)
    else $error("soft start not read back");
  a_done_when_idle: assert property ($rose(soft_done_irq) |-> !busy)
    else $error("done irq while transfer runs");
  a_done_cleared: assert property (s_soft_clear |-> ##2 !soft_done_irq)
    else $error("done irq kept after soft clear");
  a_stop_idle: assert property (stopped |-> !busy)
    else $error("stop accepted while engine busy");
  a_stop_after_clear: assert property (
      req && we && addr == REG_MSTOP && wdata[0] |-> en_zero)
    else $error("stop written with enables set");
  a_enable_rmw: assert property (
      req && we && addr == REG_ENABLE && wdata != 8'h00 |->
      en_rd_ok && $countones(wdata ^ en_rd) <= 1)
    else $error("enable write without single bit change");
  a_ram_kept: assert property (req && we && addr == REG_SYSCTL |-> wdata[0])
    else $error("ram enable cleared");
endmodule
`default_nettype wire

// ==== tb/test_transfer_controller_activation.sv ====
// self-checking bench for the controller and its cpu side facing each other
`default_nettype none
module test_transfer_controller_activation;
  timeunit 1ns;
  timeprecision 1ps;
  import tca_pkg::*;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [11:0] avs_address = 12'h000;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [7:0] src_flag = 8'h00;
  logic [7:0] src_clr;
  logic [7:0] cpu_irq;
  logic soft_done;
  int fail_count = 0;
  int cmp_count = 0;
  int cycles = 0;
  int clr_cnt = 0;
  tca_if tca_link();
  tca_device tca_device_i (.core_clk_i(core_clk_i), .rst_i(rst_i), .src_flag_i(src_flag),
    .src_clr_o(src_clr), .link(tca_link.dev));
  tca_host tca_host_i (.core_clk_i(core_clk_i), .rst_i(rst_i), .avs_address_i(avs_address),
    .avs_read_i(avs_read), .avs_write_i(avs_write), .avs_writedata_i(avs_writedata),
    .avs_readdata_o(avs_readdata), .avs_waitrequest_o(avs_waitrequest),
    .cpu_irq_o(cpu_irq), .soft_done_irq_o(soft_done), .link(tca_link.host));
  tca_asserts tca_asserts_i (.core_clk_i(core_clk_i), .rst_i(rst_i), .req(tca_link.req),
    .we(tca_link.we), .addr(tca_link.addr), .wdata(tca_link.wdata), .ack(tca_link.ack),
    .rdata(tca_link.rdata), .cpu_irq(tca_link.cpu_irq),
    .soft_done_irq(tca_link.soft_done_irq), .busy(tca_link.busy));
  always #2 core_clk_i = ~core_clk_i;
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // peripheral model: a clear pulse drops the source flag
  always @(posedge core_clk_i) begin
    cycles <= cycles + 1;
    for (int j = 0; j < 8; j++) begin
      if (src_clr[j] === 1'b1) begin
        src_flag[j] <= 1'b0;
        clr_cnt <= clr_cnt + 1;
      end
    end
    if (cycles == 40000) begin
      fail_count++;
      end_of_test();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic av(input logic [11:0] a, input logic w, input logic [31:0] d,
      output logic [31:0] q);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    // hold the request until waitrequest is sampled low at a rising edge
    do @(posedge core_clk_i); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge core_clk_i);
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] q;
    av(a, 1'b1, {24'h00_0000, d}, q);
  endtask
  task automatic ram_chk(input logic [11:0] a, input logic [7:0] e);
    logic [31:0] q;
    av(a, 1'b0, 32'h0000_0000, q);
    chk(q, {24'h00_0000, e});
  endtask
  function automatic logic sig(input int k);
    case (k)
      0: return tca_link.busy;
      1: return soft_done;
      default: return cpu_irq[k-2];
    endcase
  endfunction
  task automatic wait_sig(input int k, input logic v);
    int i;
    i = 0;
    do begin
      @(negedge core_clk_i);
      i++;
    end while (i < 3000 && sig(k) !== v);
    chk(sig(k), v);
    @(posedge core_clk_i);
  endtask
  task automatic set_info(input logic [6:0] vec, input logic [11:0] base, input logic [7:0] ma,
      input logic [15:0] sp, input logic [15:0] dp, input logic [15:0] ca, input logic [15:0] cb);
    logic [79:0] ri;
    logic [11:0] va;
    ri = {ma, 8'h00, sp, dp, ca, cb};
    va = 12'h400 + {4'h0, vec, 1'b0};
    wr(va, {4'h0, base[11:8]});
    wr(va + 12'h001, base[7:0]);
    for (int i = 0; i < 10; i++) wr(base + 12'(i), ri[79 - 8 * i -: 8]);
  endtask
  task automatic fire(input int k);
    src_flag[k] <= 1'b1;
    wait_sig(0, 1'b1);
    wait_sig(0, 1'b0);
  endtask
  task automatic t_normal();
    int n;
    n = clr_cnt;
    set_info(7'h40, 12'h100, 8'h20, 16'h0010, 16'h0200, 16'h0080, 16'h0000);
    wr(CMD_EN_SET, 8'h00);
    for (int i = 0; i < 128; i++) fire(0);
    wait_sig(2, 1'b1);
    chk(clr_cnt - n, 127);
    chk(src_flag, 8'h01);
    chk(cpu_irq, 8'h01);
    for (int i = 0; i < 128; i++) ram_chk(12'h200 + 12'(i), 8'hC3);
    ram_chk(12'h280, 8'h00);
    ram_chk(12'h102, 8'h00);
    ram_chk(12'h103, 8'h10);
    ram_chk(12'h104, 8'h02);
    ram_chk(12'h105, 8'h80);
    ram_chk(12'h107, 8'h00);
    wr(12'h107, 8'h01);
    wr(CMD_EN_SET, 8'h00);
    wait_sig(2, 1'b1);
    ram_chk(12'h280, 8'hC3);
    src_flag[0] <= 1'b0;
    wait_sig(2, 1'b0);
  endtask
  task automatic t_block();
    logic [31:0] q;
    for (int i = 0; i < 128; i++) wr(12'h300 + 12'(i), 8'(i) ^ 8'h5A);
    set_info(7'h60, 12'h140, 8'hA8, 16'h0300, 16'h0600, 16'h8080, 16'h0001);
    wr(CMD_SOFT, 8'h60);
    wait_sig(1, 1'b1);
    for (int i = 0; i < 128; i++) ram_chk(12'h600 + 12'(i), 8'(i) ^ 8'h5A);
    ram_chk(12'h146, 8'h80);
    ram_chk(12'h147, 8'h80);
    ram_chk(12'h149, 8'h00);
    av(CMD_STATUS, 1'b0, 32'h0000_0000, q);
    chk(q[9:8], 2'b10);
    wr(CMD_SOFT_CLR, 8'h00);
    wait_sig(1, 1'b0);
  endtask
  task automatic t_single();
    set_info(7'h61, 12'h160, 8'hA0, 16'h0300, 16'h0700, 16'h0002, 16'h0000);
    wr(CMD_SOFT, 8'h61);
    wait_sig(0, 1'b0);
    chk(soft_done, 1'b0);
    wr(CMD_SOFT, 8'h61);
    wait_sig(1, 1'b1);
    ram_chk(12'h701, 8'h5B);
    wr(CMD_SOFT_CLR, 8'h00);
    wait_sig(1, 1'b0);
  endtask
  task automatic t_stop();
    logic [31:0] q;
    set_info(7'h41, 12'h180, 8'hA0, 16'h0300, 16'h0780, 16'h0004, 16'h0000);
    wr(CMD_EN_SET, 8'h01);
    src_flag[1] <= 1'b1;
    wait_sig(0, 1'b1);
    wr(CMD_STOP, 8'h01);
    av(CMD_SOFT, 1'b0, 32'h0000_0000, q);
    chk(q[9], 1'b0);
    wait_sig(0, 1'b0);
    wr(CMD_STOP, 8'h01);
    av(CMD_SOFT, 1'b0, 32'h0000_0000, q);
    chk(q[9], 1'b1);
    wr(CMD_STOP, 8'h00);
    ram_chk(12'h780, 8'h5A);
  endtask
  // chained pair on source 2: first block would complete, last is repeat mode
  task automatic t_chain();
    int n;
    n = clr_cnt;
    set_info(7'h42, 12'h1AA, 8'hA4, 16'h0301, 16'h07B0, 16'h0303, 16'h0000);
    set_info(7'h42, 12'h1A0, 8'hA0, 16'h0300, 16'h07A0, 16'h0001, 16'h0000);
    wr(12'h1A1, 8'hC0);
    wr(CMD_EN_SET, 8'h02);
    fire(2);
    chk(clr_cnt - n, 1);
    chk(cpu_irq, 8'h00);
    ram_chk(12'h7A0, 8'h5A);
    ram_chk(12'h7B0, 8'h5B);
    ram_chk(12'h1A7, 8'h00);
    ram_chk(12'h1B1, 8'h02);
    wr(CMD_EN_CLR, 8'h02);
  endtask
  // soft start with per-transfer interrupt, word units, decrementing destination
  task automatic t_per_transfer_irq_select();
    set_info(7'h62, 12'h1C0, 8'hB1, 16'h0300, 16'h07C0, 16'h0005, 16'h0000);
    wr(12'h1C1, 8'h40);
    wr(CMD_SOFT, 8'h62);
    wait_sig(1, 1'b1);
    ram_chk(12'h1C7, 8'h04);
    ram_chk(12'h7C0, 8'h5A);
    ram_chk(12'h7C1, 8'h5B);
    ram_chk(12'h1C5, 8'hBE);
    wr(CMD_SOFT_CLR, 8'h00);
    wait_sig(1, 1'b0);
  endtask
  initial begin
    repeat (10) @(posedge core_clk_i);
    rst_i <= 1'b0;
    @(posedge core_clk_i);
    wr(CMD_SYSCTL, 8'h01);
    wr(12'h280, 8'h00);
    wr(12'h010, 8'hC3);
    t_normal();
    t_block();
    t_single();
    t_stop();
    t_chain();
    t_per_transfer_irq_select();
    end_of_test();
  end
endmodule
`default_nettype wire
